//--- design/ettg_pkg.sv
// ettg_pkg: constants, modes and carriers of the test traffic generator.
// assumes one 50 MHz bus clock; one line byte leaves per clock cycle.
package ettg_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_SIZE  = 8'h04;
	localparam logic [7:0] OFF_STEP  = 8'h08;
	localparam logic [7:0] OFF_DUR   = 8'h0c;
	localparam logic [7:0] OFF_LOAD  = 8'h10;
	localparam logic [7:0] OFF_RAMP  = 8'h14;
	localparam logic [7:0] OFF_BURST = 8'h18;
	localparam logic [7:0] OFF_BGAP  = 8'h1c;
	localparam logic [7:0] OFF_BFRM  = 8'h20;
	localparam logic [7:0] OFF_STAT  = 8'h24;
	localparam logic [7:0] OFF_FRMS  = 8'h28;
	localparam logic [7:0] OFF_DISR  = 8'h2c;
	// control field positions
	localparam int CB_TEST_GO  = 0;
	localparam int CB_GEN_GO   = 1;
	localparam int CB_STOP     = 2;
	localparam int CB_AUTO     = 3;
	localparam int CB_BURST    = 4;
	localparam int CB_DUR      = 5;
	localparam int CB_SIZE     = 7;
	localparam int CB_LRAMP    = 9;
	localparam int CB_RMODE    = 10;
	localparam int CB_BMODE    = 12;
	localparam int CB_BCNT     = 14;
	localparam int CB_MSEC     = 15;
	localparam int CB_SEQ      = 16;
	localparam int CB_LOS      = 17;
	// reset values
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_SIZE = 32'h05dc_0040;
	localparam logic [31:0] RST_STEP = 32'h0001_0001;
	localparam logic [31:0] RST_LOAD = 32'h0030_0030;
	localparam logic [31:0] RST_RAMP = 32'h0001_0004;
	localparam logic [31:0] RST_BRST = 32'h0bb8_05dc;
	localparam logic [31:0] RST_BGAP = 32'h0001_05dc;
	localparam logic [31:0] RST_BFRM = 32'h0001_0040;
	// line figures, gaps kept in quarter bytes
	localparam logic [15:0] IFG_FULL_Q   = 16'h0030;
	localparam logic [15:0] PREAMBLE_B   = 16'h0008;
	localparam logic [15:0] BURST_OVH_B  = 16'h0014;
	// time bases
	localparam int CLK_HZ      = 50_000_000;
	localparam int SEC_TIME_S  = 1;
	localparam int MS_TIME_MS  = 1;
	localparam int CYC_PER_SEC = CLK_HZ * SEC_TIME_S;
	localparam int CYC_PER_MS  = (CLK_HZ / 1000) * MS_TIME_MS;
	typedef enum logic [1:0] {DUR_CONT, DUR_SECS, DUR_FRMS} ettg_dur_t;
	typedef enum logic [1:0] {SZ_CONST, SZ_STEP, SZ_RAND, SZ_INCR} ettg_size_t;
	typedef enum logic [1:0] {RM_KEEP, RM_REPEAT, RM_INVERT} ettg_rmode_t;
	typedef enum logic [1:0] {BM_OFF, BM_CONST, BM_RAMP} ettg_bmode_t;
	typedef enum {ST_IDLE, ST_FRAME, ST_GAP, ST_BGAP} ettg_state_t;
	typedef struct packed {
		logic        sof;
		logic        busy;
		logic [15:0] len;
	} ettg_tx_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] seq;
	} ettg_rx_t;
endpackage

//--- design/ettg_top.sv
// ettg_top: ahb-lite register slave, per-stream frame scheduler, rx checks.
// assumes one byte time per hclk; rx strobes are synchronous to hclk.
//
// What this block does
// - normal mode sends plain frames back to back, never grouped in bursts
// - burst mode sends frames only inside bursts
// - continuous with auto-start begins sending in the test start cycle, but gives no sof if it lands mid-frame
// - load given as gap: 12 bytes is full rate, met on average
// - ramped load steps start to end, holding steps, optional ms units
// - after a ramp: hold end, restart from start, or reverse
// - constant size mode sends the start size all test long
// - stepped size advances by step, each size held given seconds
// - continuous duration wraps stepped sizes back to start forever
// - seconds duration stops sending once total time is up
// - frames duration stops when sent count equals configured number
// - random size mode draws sizes uniformly from start to end
// - incremental mode grows each frame by one byte toward end
// - frame size excludes preamble and gap, added outside it
// - constant bursts use fixed lengths; burst mode off stops stream
// - ramped bursts vary length start to end per ramp mode
// - enabled burst count stops stream after exactly that many bursts
// - inter-burst gap is met as an average over gaps
// - burst length counts each frame as burst frame size plus 20
// - optional sequence number check on received frames
// - packet disruption counted, while los mode is off, when frame number jumps by more than skip
// - loss-of-signal disruption counted on each loss event
`timescale 1ns/1ps
module ettg_top #(
	parameter int SEC_CYC = ettg_pkg::CYC_PER_SEC,
	parameter int MS_CYC  = ettg_pkg::CYC_PER_MS
) (
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic               hready,
	input  wire logic [31:0]        hwdata,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// line side
	output ettg_pkg::ettg_tx_t      tx,
	input  wire ettg_pkg::ettg_rx_t rx,
	input  wire logic               rx_los,
	// status
	output logic                    gen_running
);
	logic [31:0] ctrl_ff, size_ff, step_ff, dur_ff, load_ff, ramp_ff;
	logic [31:0] brst_ff, bgap_ff, bfrm_ff;
	logic [31:0] frames_ff, secs_ff, bursts_ff;
	logic [15:0] disr_ff, seqerr_ff;
	logic        wr_pend_ff;
	logic [7:0]  wr_addr_ff;
	logic        go_pulse, stop_req, stop_ff;
	ettg_pkg::ettg_state_t state_ff;
	logic        run_ff;
	logic [15:0] cnt_ff, cur_size_ff, cur_gap_ff, cur_blen_ff;
	logic [15:0] lfsr_ff, brem_ff;
	logic [1:0]  gap_frac_ff, bgap_frac_ff;
	logic        ldir_ff, bdir_ff;
	logic [31:0] sec_cnt_ff, ms_cnt_ff;
	logic        sec_tick, ms_tick;
	logic [15:0] lstep_cnt_ff, sstep_cnt_ff;
	logic [31:0] last_seq_ff;
	logic        seq_seen_ff, los_d_ff;
	ettg_pkg::ettg_tx_t nxt_tx;

	wire ettg_pkg::ettg_dur_t   dmode = ettg_pkg::ettg_dur_t'(ctrl_ff[6:5]);
	wire ettg_pkg::ettg_size_t  smode = ettg_pkg::ettg_size_t'(ctrl_ff[8:7]);
	wire ettg_pkg::ettg_rmode_t rmode =
		ettg_pkg::ettg_rmode_t'(ctrl_ff[11:10]);
	wire ettg_pkg::ettg_bmode_t bmode =
		ettg_pkg::ettg_bmode_t'(ctrl_ff[13:12]);
	wire burst_on = ctrl_ff[ettg_pkg::CB_BURST];

	// one ramp step toward the current target; returns {dir, value}
	function automatic logic [16:0] ramp_next(input logic [15:0] cur,
			input logic [15:0] lo, input logic [15:0] hi,
			input logic [15:0] step, input ettg_pkg::ettg_rmode_t m,
			input logic dir);
		logic [15:0] tgt;
		logic [16:0] res;
		tgt = dir ? lo : hi;
		res = {dir, cur};
		if (cur == tgt) begin
			if (m == ettg_pkg::RM_REPEAT)
				res = {1'b0, lo};
			else if (m == ettg_pkg::RM_INVERT)
				res = {~dir, cur};
		end else if (tgt > cur) begin
			res = {dir, (tgt - cur > step) ? 16'(cur + step) : tgt};
		end else begin
			res = {dir, (cur - tgt > step) ? 16'(cur - step) : tgt};
		end
		return res;
	endfunction

	// quarter-byte gap plus carried error; returns {whole bytes, new frac}
	function automatic logic [17:0] gap_acc(input logic [15:0] gq,
			input logic [1:0] frac);
		logic [16:0] s;
		s = {1'b0, gq} + {15'h0000, frac};
		return {1'b0, s};
	endfunction

	// smallest all-ones mask covering the span
	function automatic logic [15:0] span_mask(input logic [15:0] v);
		logic [15:0] m;
		m = v;
		m = m | (m >> 1);
		m = m | (m >> 2);
		m = m | (m >> 4);
		m = m | (m >> 8);
		return m;
	endfunction

	// ahb-lite: zero wait states, read data latched in the address phase
	wire addr_ok = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata     <= 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			wr_pend_ff <= addr_ok && hwrite;
			wr_addr_ff <= haddr[7:0];
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			if (addr_ok && !hwrite) begin
				if (haddr[7:0] == ettg_pkg::OFF_CTRL)
					hrdata <= ctrl_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_SIZE)
					hrdata <= size_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_STEP)
					hrdata <= step_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_DUR)
					hrdata <= dur_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_LOAD)
					hrdata <= load_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_RAMP)
					hrdata <= ramp_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_BURST)
					hrdata <= brst_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_BGAP)
					hrdata <= bgap_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_BFRM)
					hrdata <= bfrm_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_STAT)
					hrdata <= {cur_size_ff, 15'h0000, run_ff};
				else if (haddr[7:0] == ettg_pkg::OFF_FRMS)
					hrdata <= frames_ff;
				else if (haddr[7:0] == ettg_pkg::OFF_DISR)
					hrdata <= {seqerr_ff, disr_ff};
				else
					hrdata <= 32'h0000_0000;
			end
		end
	end

	wire wr_ctrl = wr_pend_ff && wr_addr_ff == ettg_pkg::OFF_CTRL;
	// go/stop bits are self-clearing strobes, never stored
	assign go_pulse = wr_ctrl && (hwdata[ettg_pkg::CB_GEN_GO] ||
		(hwdata[ettg_pkg::CB_TEST_GO] && hwdata[ettg_pkg::CB_AUTO] &&
		hwdata[6:5] == 2'(ettg_pkg::DUR_CONT)));
	assign stop_req = wr_ctrl && hwdata[ettg_pkg::CB_STOP];
	// first frame sized from the start write, not from stale mode state
	wire [15:0] go_size = hwdata[ettg_pkg::CB_BURST] ? bfrm_ff[15:0] :
		size_ff[15:0];

	// a stop strobe that lands mid-frame is held until the next gap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			stop_ff <= 1'b0;
		else if (go_pulse)
			stop_ff <= 1'b0;
		else if (stop_req)
			stop_ff <= 1'b1;
		else if (state_ff == ettg_pkg::ST_IDLE)
			stop_ff <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= ettg_pkg::RST_CTRL;
			size_ff <= ettg_pkg::RST_SIZE;
			step_ff <= ettg_pkg::RST_STEP;
			dur_ff  <= 32'h0000_0000;
			load_ff <= ettg_pkg::RST_LOAD;
			ramp_ff <= ettg_pkg::RST_RAMP;
			brst_ff <= ettg_pkg::RST_BRST;
			bgap_ff <= ettg_pkg::RST_BGAP;
			bfrm_ff <= ettg_pkg::RST_BFRM;
		end else if (wr_pend_ff) begin
			if (wr_addr_ff == ettg_pkg::OFF_CTRL)
				ctrl_ff <= {14'h0000, hwdata[17:3], 3'b000};
			else if (wr_addr_ff == ettg_pkg::OFF_SIZE)
				size_ff <= hwdata;
			else if (wr_addr_ff == ettg_pkg::OFF_STEP)
				step_ff <= hwdata;
			else if (wr_addr_ff == ettg_pkg::OFF_DUR)
				dur_ff <= hwdata;
			else if (wr_addr_ff == ettg_pkg::OFF_LOAD)
				load_ff <= hwdata;
			else if (wr_addr_ff == ettg_pkg::OFF_RAMP)
				ramp_ff <= hwdata;
			else if (wr_addr_ff == ettg_pkg::OFF_BURST)
				brst_ff <= hwdata;
			else if (wr_addr_ff == ettg_pkg::OFF_BGAP)
				bgap_ff <= hwdata;
			else if (wr_addr_ff == ettg_pkg::OFF_BFRM)
				bfrm_ff <= hwdata;
		end
	end

	// time bases restart with every generator start
	assign sec_tick = run_ff && sec_cnt_ff == 32'(SEC_CYC - 1);
	assign ms_tick  = run_ff && ms_cnt_ff == 32'(MS_CYC - 1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_cnt_ff <= 32'h0000_0000;
			ms_cnt_ff  <= 32'h0000_0000;
			secs_ff    <= 32'h0000_0000;
		end else if (go_pulse || !run_ff) begin
			sec_cnt_ff <= 32'h0000_0000;
			ms_cnt_ff  <= 32'h0000_0000;
			if (go_pulse)
				secs_ff <= 32'h0000_0000;
		end else begin
			sec_cnt_ff <= sec_tick ? 32'h0000_0000 : sec_cnt_ff + 32'h1;
			ms_cnt_ff  <= ms_tick ? 32'h0000_0000 : ms_cnt_ff + 32'h1;
			if (sec_tick)
				secs_ff <= secs_ff + 32'h1;
		end
	end

	// end of traffic by time, frame count, burst count or burst mode off
	wire time_up   = dmode == ettg_pkg::DUR_SECS && secs_ff >= dur_ff;
	wire frame_end = state_ff == ettg_pkg::ST_FRAME && cnt_ff == 16'h0001;
	wire frms_up   = dmode == ettg_pkg::DUR_FRMS &&
		frames_ff + 32'h1 >= dur_ff;
	wire bcnt_up   = ctrl_ff[ettg_pkg::CB_BCNT] &&
		bursts_ff + 32'h1 >= {16'h0000, bgap_ff[31:16]};
	wire need_stop = stop_req || stop_ff || time_up ||
		(burst_on && bmode == ettg_pkg::BM_OFF);

	// ramp and size stepping
	wire lstep_tick = ctrl_ff[ettg_pkg::CB_MSEC] ? ms_tick : sec_tick;
	wire [16:0] lramp = ramp_next(cur_gap_ff, load_ff[15:0],
		load_ff[31:16], ramp_ff[15:0], rmode, ldir_ff);
	wire [16:0] bramp = ramp_next(cur_blen_ff, brst_ff[15:0],
		brst_ff[31:16], ramp_ff[15:0], rmode, bdir_ff);
	wire [15:0] span = 16'(size_ff[31:16] - size_ff[15:0]);
	wire [15:0] cand = lfsr_ff & span_mask(span);
	wire        cand_ok = cand <= span;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			lfsr_ff <= 16'hace1;
		else
			lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^
				lfsr_ff[12] ^ lfsr_ff[10]};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_gap_ff   <= ettg_pkg::IFG_FULL_Q;
			ldir_ff      <= 1'b0;
			lstep_cnt_ff <= 16'h0000;
		end else if (go_pulse) begin
			cur_gap_ff   <= load_ff[15:0];
			ldir_ff      <= 1'b0;
			lstep_cnt_ff <= 16'h0000;
		end else if (ctrl_ff[ettg_pkg::CB_LRAMP] && lstep_tick) begin
			if (lstep_cnt_ff + 16'h1 >= ramp_ff[31:16]) begin
				lstep_cnt_ff <= 16'h0000;
				{ldir_ff, cur_gap_ff} <= lramp;
			end else begin
				lstep_cnt_ff <= lstep_cnt_ff + 16'h1;
			end
		end else if (!ctrl_ff[ettg_pkg::CB_LRAMP]) begin
			cur_gap_ff <= load_ff[15:0];
		end
	end

	// last idle byte also decides the start, so a load of n gives n idles
	wire gap_last  = cnt_ff <= 16'h0001;
	wire size_pick = (state_ff == ettg_pkg::ST_GAP ||
		state_ff == ettg_pkg::ST_BGAP) && gap_last;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_size_ff  <= ettg_pkg::RST_SIZE[15:0];
			sstep_cnt_ff <= 16'h0000;
		end else if (go_pulse) begin
			cur_size_ff  <= size_ff[15:0];
			sstep_cnt_ff <= 16'h0000;
		end else if (smode == ettg_pkg::SZ_CONST) begin
			cur_size_ff <= size_ff[15:0];
		end else if (smode == ettg_pkg::SZ_STEP && sec_tick) begin
			if (sstep_cnt_ff + 16'h1 >= step_ff[31:16]) begin
				sstep_cnt_ff <= 16'h0000;
				if (cur_size_ff + step_ff[15:0] > size_ff[31:16])
					cur_size_ff <= size_ff[15:0];
				else
					cur_size_ff <= 16'(cur_size_ff + step_ff[15:0]);
			end else begin
				sstep_cnt_ff <= sstep_cnt_ff + 16'h1;
			end
		end else if (smode == ettg_pkg::SZ_RAND && size_pick && cand_ok) begin
			cur_size_ff <= 16'(size_ff[15:0] + cand);
		end else if (smode == ettg_pkg::SZ_INCR && frame_end) begin
			cur_size_ff <= (cur_size_ff >= size_ff[31:16]) ?
				size_ff[15:0] : 16'(cur_size_ff + 16'h1);
		end
	end

	// a random pick waits for an in-range draw so no size is favoured
	wire pick_ok = smode != ettg_pkg::SZ_RAND || cand_ok;
	wire [15:0] fsize = burst_on ? bfrm_ff[15:0] : cur_size_ff;
	wire [17:0] ngap = gap_acc(cur_gap_ff < ettg_pkg::IFG_FULL_Q ?
		ettg_pkg::IFG_FULL_Q : cur_gap_ff, gap_frac_ff);
	wire [17:0] nbgap = gap_acc(bgap_ff[15:0], bgap_frac_ff);

	// scheduler: frame bytes, then idle bytes, bursts bounded by brem
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff     <= ettg_pkg::ST_IDLE;
			run_ff       <= 1'b0;
			cnt_ff       <= 16'h0000;
			gap_frac_ff  <= 2'b00;
			bgap_frac_ff <= 2'b00;
			brem_ff      <= 16'h0000;
			cur_blen_ff  <= 16'h0000;
			bdir_ff      <= 1'b0;
			frames_ff    <= 32'h0000_0000;
			bursts_ff    <= 32'h0000_0000;
		end else if (go_pulse) begin
			// start goes straight to the first frame byte
			state_ff     <= ettg_pkg::ST_FRAME;
			run_ff       <= 1'b1;
			cnt_ff       <= 16'(go_size + ettg_pkg::PREAMBLE_B);
			gap_frac_ff  <= 2'b00;
			bgap_frac_ff <= 2'b00;
			cur_blen_ff  <= brst_ff[15:0];
			brem_ff      <= brst_ff[15:0];
			bdir_ff      <= 1'b0;
			frames_ff    <= 32'h0000_0000;
			bursts_ff    <= 32'h0000_0000;
		end else begin
			case (state_ff)
			ettg_pkg::ST_IDLE: begin
				run_ff <= 1'b0;
			end
			ettg_pkg::ST_FRAME: begin
				cnt_ff <= 16'(cnt_ff - 16'h1);
				if (cnt_ff == 16'h0001) begin
					frames_ff <= frames_ff + 32'h1;
					brem_ff   <= 16'(brem_ff - fsize -
						ettg_pkg::BURST_OVH_B);
					if (frms_up) begin
						state_ff <= ettg_pkg::ST_IDLE;
					end else if (burst_on && 16'(brem_ff - fsize -
							ettg_pkg::BURST_OVH_B) <
							16'(fsize + ettg_pkg::BURST_OVH_B)) begin
						bursts_ff <= bursts_ff + 32'h1;
						if (bcnt_up) begin
							state_ff <= ettg_pkg::ST_IDLE;
						end else begin
							state_ff     <= ettg_pkg::ST_BGAP;
							cnt_ff       <= nbgap[17:2];
							bgap_frac_ff <= nbgap[1:0];
						end
					end else begin
						// inside a burst frames go at full rate
						state_ff    <= ettg_pkg::ST_GAP;
						cnt_ff      <= burst_on ? 16'(ettg_pkg::IFG_FULL_Q >> 2)
							: ngap[17:2];
						gap_frac_ff <= burst_on ? gap_frac_ff : ngap[1:0];
					end
				end
			end
			default: begin
				if (cnt_ff != 16'h0000)
					cnt_ff <= 16'(cnt_ff - 16'h1);
				if (need_stop) begin
					state_ff <= ettg_pkg::ST_IDLE;
				end else if (gap_last && pick_ok) begin
					state_ff <= ettg_pkg::ST_FRAME;
					cnt_ff   <= 16'(fsize + ettg_pkg::PREAMBLE_B);
					if (state_ff == ettg_pkg::ST_BGAP) begin
						if (bmode == ettg_pkg::BM_RAMP) begin
							{bdir_ff, cur_blen_ff} <= bramp;
							brem_ff <= bramp[15:0];
						end else begin
							cur_blen_ff <= brst_ff[15:0];
							brem_ff     <= brst_ff[15:0];
						end
					end
				end
			end
			endcase
		end
	end

	always_comb begin
		nxt_tx.sof  = state_ff != ettg_pkg::ST_FRAME && go_pulse;
		nxt_tx.busy = go_pulse || (state_ff == ettg_pkg::ST_FRAME &&
			cnt_ff != 16'h0001);
		nxt_tx.len  = go_pulse ? go_size : fsize;
		if (!go_pulse && !need_stop && pick_ok && gap_last &&
				(state_ff == ettg_pkg::ST_GAP ||
				state_ff == ettg_pkg::ST_BGAP)) begin
			nxt_tx.sof  = 1'b1;
			nxt_tx.busy = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx          <= '0;
			gen_running <= 1'b0;
		end else begin
			tx          <= nxt_tx;
			gen_running <= go_pulse || (run_ff &&
				state_ff != ettg_pkg::ST_IDLE);
		end
	end

	// receive checks
	wire [31:0] seq_jump = rx.seq - last_seq_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_seq_ff <= 32'h0000_0000;
			seq_seen_ff <= 1'b0;
			los_d_ff    <= 1'b0;
			disr_ff     <= 16'h0000;
			seqerr_ff   <= 16'h0000;
		end else begin
			los_d_ff <= rx_los;
			if (rx.valid) begin
				last_seq_ff <= rx.seq;
				seq_seen_ff <= 1'b1;
			end
			if (ctrl_ff[ettg_pkg::CB_SEQ] && rx.valid && seq_seen_ff &&
					seq_jump != 32'h1)
				seqerr_ff <= seqerr_ff + 16'h1;
			if (ctrl_ff[ettg_pkg::CB_LOS]) begin
				if (rx_los && !los_d_ff)
					disr_ff <= disr_ff + 16'h1;
			end else if (rx.valid && seq_seen_ff && seq_jump >=
					{16'h0000, bfrm_ff[31:16]} + 32'h1) begin
				disr_ff <= disr_ff + 16'h1;
			end
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_start_auto;
		wr_ctrl && hwdata[ettg_pkg::CB_TEST_GO] &&
			hwdata[ettg_pkg::CB_AUTO] && hwdata[6:5] == 2'b00;
	endsequence
	a_auto_start_now: assert property (s_start_auto |=> tx.sof && tx.busy)
		else $error("auto start did not send at once");
	a_no_burst_gap: assert property (!burst_on |-> state_ff != ettg_pkg::ST_BGAP)
		else $error("burst gap in normal mode");
	a_gap_at_least: assert property (frame_end && !burst_on && !frms_up
		&& !go_pulse |=> cnt_ff >= 16'h000c)
		else $error("gap below twelve bytes");
	a_frames_stop: assert property (frame_end && frms_up && !go_pulse
		|=> state_ff == ettg_pkg::ST_IDLE)
		else $error("frame count not honoured");
	a_const_size: assert property (smode == ettg_pkg::SZ_CONST && !go_pulse
		&& !wr_pend_ff |=> cur_size_ff == size_ff[15:0])
		else $error("constant size drifted");
	a_rand_range: assert property (smode == ettg_pkg::SZ_RAND && frame_end
		|-> cur_size_ff <= size_ff[31:16])
		else $error("random size out of range");
	a_los_count: assert property (ctrl_ff[ettg_pkg::CB_LOS] && rx_los
		&& !los_d_ff |=> disr_ff == $past(disr_ff) + 16'h1)
		else $error("los event not counted");
	a_bmode_off: assert property (burst_on && bmode == ettg_pkg::BM_OFF &&
		state_ff == ettg_pkg::ST_GAP && !go_pulse
		|=> state_ff == ettg_pkg::ST_IDLE)
		else $error("burst off did not stop");
	a_time_stop: assert property (time_up && state_ff == ettg_pkg::ST_GAP
		&& !go_pulse |=> ##[0:1] state_ff == ettg_pkg::ST_IDLE)
		else $error("seconds limit ignored");
endmodule

//--- tb/ettg_net_model.sv
// ettg_net_model: far-side network looping each sent frame back as rx.
// assumes tx is synchronous to hclk; jump adds a skip to one frame number.
`timescale 1ns/1ps
module ettg_net_model (
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// line
	input  wire ettg_pkg::ettg_tx_t tx,
	output ettg_pkg::ettg_rx_t      rx,
	// fault injection
	input  wire logic [7:0]         jump
);
	logic [31:0] seq_ff;
	logic        vld_ff;
	// idle number is inverted so a stale value never reads as fresh
	assign rx.valid = vld_ff;
	assign rx.seq   = vld_ff ? seq_ff : ~seq_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_ff <= 32'h0;
			vld_ff <= 1'b0;
		end else begin
			vld_ff <= tx.sof;
			if (tx.sof)
				seq_ff <= seq_ff + 32'h1 + {24'h0, jump};
		end
	end
endmodule

//--- tb/test_ettg_top.sv
// test_ettg_top: self-checking bench for the traffic generator.
// assumes short second and ms bases set through the top's parameters.
`timescale 1ns/1ps
module test_ettg_top;
	logic               hclk, hresetn, hsel, hwrite, los;
	logic [31:0]        haddr, hwdata, hrdata, q;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic               hreadyout, hresp, gen_running;
	logic [7:0]         jump;
	ettg_pkg::ettg_tx_t tx;
	ettg_pkg::ettg_rx_t rx;
	int                 n_fail, checks, run, gap, t, n;
	int                 gq[$];
	logic [15:0]        lens[$];
	logic [15:0]        cur, s;
	logic [1:0]         sm[3] = '{2'h0, 2'h3, 2'h2};
	logic [7:0]         offs[8] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18,
		8'h1c, 8'h20, 8'h30};
	logic [31:0]        rsts[8] = '{ettg_pkg::RST_SIZE, ettg_pkg::RST_STEP,
		ettg_pkg::RST_LOAD, ettg_pkg::RST_RAMP, ettg_pkg::RST_BRST,
		ettg_pkg::RST_BGAP, ettg_pkg::RST_BFRM, 32'h0};
	ettg_top #(.SEC_CYC(100), .MS_CYC(10)) ettg_top_inst (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .tx(tx), .rx(rx), .rx_los(los),
		.gen_running(gen_running));
	ettg_net_model ettg_net_model_inst (.hclk(hclk), .hresetn(hresetn),
		.tx(tx), .rx(rx), .jump(jump));
	task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		k = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
		q = hrdata;
		check("hresp", hresp, 1'b0);
	endtask
	// bounded wait for the stream to end, then a quiet margin
	task automatic wait_idle();
		int k;
		k = 0;
		do @(posedge hclk); while (gen_running !== 1'b0 && ++k < 5000);
		check("stopped", gen_running, 1'b0);
		repeat (30) @(posedge hclk);
	endtask
	always @(posedge hclk) begin
		if (tx.sof === 1'b1) begin
			check("gap", gap >= 12, 1'b1);
			lens.push_back(tx.len);
			gq.push_back(gap);
			cur = tx.len;
			run = 0;
		end
		if (tx.busy === 1'b1) begin
			run++;
			gap = 0;
		end else begin
			if (gap == 0 && run > 0)
				check("busy", run, cur + 8);
			gap++;
		end
	end
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial begin
		#1000000;
		n_fail++;
		print_verdict();
	end
	initial begin
		{hresetn, hsel, hwrite, los, haddr, hwdata, htrans, hsize} = '0;
		jump = 8'h0;
		{n_fail, checks, run} = '0;
		gap = 100;
		void'($urandom(32'h272c));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, offs[i], 32'h0);
			check("reset", q, rsts[i]);
		end
		$display("test reset values done");
		for (int m = 0; m < 3; m++) begin
			s = 16'h0040 + 16'($urandom_range(60));
			lens.delete();
			gq.delete();
			bus(1'b1, ettg_pkg::OFF_SIZE, {s + 16'h0014, s});
			bus(1'b1, ettg_pkg::OFF_DUR, 32'h5);
			bus(1'b1, ettg_pkg::OFF_CTRL, (32'h2 << ettg_pkg::CB_DUR) |
				(32'(sm[m]) << ettg_pkg::CB_SIZE) | 32'h2);
			wait_idle();
			check("frames", lens.size(), 5);
			foreach (lens[i])
				if (sm[m] == 2'h2) begin
					check("rand", lens[i] >= s && lens[i] <= s + 20, 1);
				end else begin
					check("size", lens[i], sm[m] == 2'h3 ? s + i : s);
					if (i > 0)
						check("ifg", gq[i], 12);
				end
			$display("test size mode %0d done", sm[m]);
		end
		bus(1'b0, ettg_pkg::OFF_FRMS, 32'h0);
		check("sent", q, 5);
		bus(1'b1, ettg_pkg::OFF_BFRM, {16'h0003, 16'h0040});
		bus(1'b1, ettg_pkg::OFF_CTRL, (32'h1 << ettg_pkg::CB_SEQ) |
			(32'h1 << ettg_pkg::CB_AUTO) | 32'h1);
		#1;
		check("auto", tx.sof, 1'b1);
		repeat (400) @(posedge hclk);
		jump <= 8'h05;
		n = 0;
		do @(posedge hclk); while (tx.sof !== 1'b1 && ++n < 500);
		jump <= 8'h00;
		repeat (300) @(posedge hclk);
		bus(1'b1, ettg_pkg::OFF_CTRL, 32'h4);
		wait_idle();
		bus(1'b1, ettg_pkg::OFF_CTRL, 32'h1 << ettg_pkg::CB_LOS);
		repeat (2) begin
			los <= 1'b1;
			repeat (5) @(posedge hclk);
			los <= 1'b0;
			repeat (5) @(posedge hclk);
		end
		bus(1'b0, ettg_pkg::OFF_DISR, 32'h0);
		check("disr", q, {16'h0001, 16'h0003});
		$display("test auto start and rx checks done");
		// stepped sizes, 3 s limit on a 100-cycle second, size 64 to 66
		lens.delete();
		gq.delete();
		bus(1'b1, ettg_pkg::OFF_SIZE, 32'h0042_0040);
		bus(1'b1, ettg_pkg::OFF_DUR, 32'h3);
		bus(1'b1, ettg_pkg::OFF_CTRL, 32'h0000_00a2);
		wait_idle();
		t = 0;
		n = 0;
		while (t < 300) begin
			check("step", lens[n], 16'h0040 + 16'(t / 100));
			t += 84 + t / 100;
			n++;
		end
		check("secs", lens.size(), n);
		for (int i = 1; i < gq.size(); i++)
			check("ifg", gq[i], 12);
		// two constant bursts of 252 bytes, 100-byte average burst gap
		lens.delete();
		gq.delete();
		bus(1'b1, ettg_pkg::OFF_BURST, 32'h0000_00fc);
		bus(1'b1, ettg_pkg::OFF_BGAP, 32'h0002_0190);
		bus(1'b1, ettg_pkg::OFF_CTRL, 32'h0000_5012);
		wait_idle();
		check("bursts", lens.size(), 2 * (252 / 84));
		foreach (gq[i]) begin
			check("blen", lens[i], 16'h0040);
			if (i > 0)
				check("bgap", gq[i], i % 3 == 0 ? 100 : 12);
		end
		$display("test stepped sizes and bursts done");
		print_verdict();
	end
endmodule
